// ---- rtl/output_assign_regs.sv ----
// holding registers that assign functions to the four outputs and kinds to the first two
// assumes a word-addressed register port fed by the serial protocol engine
// and event, fault and control-level inputs from logic on the same clock
module output_assign_regs
	import output_assign_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// register port
	input  wire logic        reg_req,
	input  wire logic        reg_we,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic             reg_ack,
	output logic [15:0]      reg_rdata,
	output logic [7:0]       reg_exc,
	// fitted hardware straps (pins)
	input  wire logic [2:0]  first_kind_fit,
	input  wire logic [2:0]  second_kind_fit,
	// event sources, sensor fault flag and control level
	input  wire logic [14:1] source_evt,
	input  wire logic        program_aux_event_one,
	input  wire logic        program_aux_event_two,
	input  wire logic        program_aux_event_three,
	input  wire logic        sensor_fault,
	input  wire logic [15:0] ctrl_level,
	// output stage
	output logic [3:0]       out_drive,
	output logic [15:0]      out1_level,
	output logic [2:0]       first_output_kind,
	output logic [2:0]       second_output_kind
);

	////////////////////////////////////////////////////////////////////////////
	// declarations

	logic [ROLE_W-1:0] first_output_role_r;
	logic [ROLE_W-1:0] second_output_role_r;
	logic [ROLE_W-1:0] third_output_role_r;
	logic [ROLE_W-1:0] fourth_output_role_r;
	logic [2:0]        kind1_r;
	logic [2:0]        kind2_r;
	logic [15:0]       sensor_fault_drive_level_r;
	logic [2:0]        fit1_s1_r;
	logic [2:0]        fit1_s2_r;
	logic [2:0]        fit2_s1_r;
	logic [2:0]        fit2_s2_r;
	logic [1:0]        strap_cnt_r;
	logic              strap_load;
	reg_sel_t          sel;
	logic              legal;
	logic              wr_ok;
	logic [15:0]       rd_nxt;

	route_if rif ();

	////////////////////////////////////////////////////////////////////////////
	// fitted hardware straps

	// straps are pins, so they pass two flops before anything reads them
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			fit1_s1_r <= KIND_NONE;
			fit1_s2_r <= KIND_NONE;
			fit2_s1_r <= KIND_NONE;
			fit2_s2_r <= KIND_NONE;
		end
		else
		begin
			fit1_s1_r <= first_kind_fit;
			fit1_s2_r <= fit1_s1_r;
			fit2_s1_r <= second_kind_fit;
			fit2_s2_r <= fit2_s1_r;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			strap_cnt_r <= 2'h0;
		else if (strap_cnt_r != STRAP_DONE)
			strap_cnt_r <= 2'(strap_cnt_r + 2'h1);
	end

	assign strap_load = (strap_cnt_r == STRAP_LOAD);

	////////////////////////////////////////////////////////////////////////////
	// decode and write check

	assign sel = decode_addr(reg_addr);

	write_checker u_check (
		.sel   (sel),
		.wdata (reg_wdata),
		.kind1 (kind1_r),
		.kind2 (kind2_r),
		.legal (legal)
	);

	// a write that fails the check leaves the register untouched
	assign wr_ok = reg_req && reg_we && (sel != SEL_NONE) && legal;

	////////////////////////////////////////////////////////////////////////////
	// role registers

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			first_output_role_r  <= ROLE_NONE;
			second_output_role_r <= ROLE_NONE;
			third_output_role_r  <= ROLE_NONE;
			fourth_output_role_r <= ROLE_NONE;
		end
		else if (wr_ok)
		begin
			if (sel == SEL_ROLE1)
				first_output_role_r <= reg_wdata[ROLE_W-1:0];
			if (sel == SEL_ROLE2)
				second_output_role_r <= reg_wdata[ROLE_W-1:0];
			if (sel == SEL_ROLE3)
				third_output_role_r <= reg_wdata[ROLE_W-1:0];
			if (sel == SEL_ROLE4)
				fourth_output_role_r <= reg_wdata[ROLE_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// kind registers

	// the strap sets the kind once; later only the current range may change
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			kind1_r <= KIND_NONE;
			kind2_r <= KIND_NONE;
		end
		else if (strap_load)
		begin
			kind1_r <= fit1_s2_r;
			kind2_r <= fit2_s2_r;
		end
		else if (wr_ok && (sel == SEL_KIND1))
			kind1_r <= reg_wdata[2:0];
		else if (wr_ok && (sel == SEL_KIND2))
			kind2_r <= reg_wdata[2:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// fallback level

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			sensor_fault_drive_level_r <= FAIL_RESET;
		else if (wr_ok && (sel == SEL_FAIL))
			sensor_fault_drive_level_r <= reg_wdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// register port answer

	always_comb
	begin
		rd_nxt = 16'h0000;
		case (sel)
			SEL_ROLE1: rd_nxt = 16'(first_output_role_r);
			SEL_KIND1: rd_nxt = 16'(kind1_r);
			SEL_FAIL:  rd_nxt = sensor_fault_drive_level_r;
			SEL_ROLE2: rd_nxt = 16'(second_output_role_r);
			SEL_KIND2: rd_nxt = 16'(kind2_r);
			SEL_ROLE3: rd_nxt = 16'(third_output_role_r);
			SEL_ROLE4: rd_nxt = 16'(fourth_output_role_r);
			default:   rd_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			reg_ack   <= 1'b0;
			reg_rdata <= 16'h0000;
			reg_exc   <= EXC_NONE;
		end
		else
		begin
			reg_ack <= reg_req;
			if (reg_req)
			begin
				reg_rdata <= reg_we ? 16'h0000 : rd_nxt;
				if (sel == SEL_NONE)
					reg_exc <= EXC_ADDR;
				else if (reg_we && !legal)
					reg_exc <= EXC_DATA;
				else
					reg_exc <= EXC_NONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output routing

	assign rif.role[0] = first_output_role_r;
	assign rif.role[1] = second_output_role_r;
	assign rif.role[2] = third_output_role_r;
	assign rif.role[3] = fourth_output_role_r;
	assign rif.src     = {program_aux_event_three, program_aux_event_two,
		program_aux_event_one, source_evt, 1'b0};

	output_router u_router (
		.rif (rif.router)
	);

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			out_drive          <= 4'h0;
			out1_level         <= 16'h0000;
			first_output_kind  <= KIND_NONE;
			second_output_kind <= KIND_NONE;
		end
		else
		begin
			out_drive          <= rif.drive;
			// proportional control falls back to the stored level on a dead sensor
			out1_level         <= (sensor_fault && (first_output_role_r == ROLE_CTRL))
				? sensor_fault_drive_level_r : ctrl_level;
			first_output_kind  <= kind1_r;
			second_output_kind <= kind2_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_role1_range;
		first_output_role_r <= ROLE1_MAX;
	endproperty
	a_role1_range: assert property (p_role1_range)
		else $error("output 1 role out of range");

	// the strap value must reach the register and then the kind output
	property p_kind1_load;
		strap_load |=> (kind1_r == $past(fit1_s2_r))
			##1 (first_output_kind == $past(fit1_s2_r, 2));
	endproperty
	a_kind1_load: assert property (p_kind1_load)
		else $error("output 1 kind not taken from strap");

	property p_kind1_ro;
		(!strap_load && !(wr_ok && sel == SEL_KIND1)) |=> $stable(kind1_r);
	endproperty
	a_kind1_ro: assert property (p_kind1_ro)
		else $error("output 1 kind changed without legal write");

	property p_kind1_swap;
		(wr_ok && sel == SEL_KIND1) |-> is_current(kind1_r)
			##1 is_current(kind1_r) && kind1_r == $past(reg_wdata[2:0]);
	endproperty
	a_kind1_swap: assert property (p_kind1_swap)
		else $error("output 1 kind written outside current range");

	property p_fail_drive;
		(sensor_fault && first_output_role_r == ROLE_CTRL)
			|=> out1_level == $past(sensor_fault_drive_level_r);
	endproperty
	a_fail_drive: assert property (p_fail_drive)
		else $error("fallback level not driven on sensor fault");

	property p_fail_range;
		sensor_fault_drive_level_r <= FAIL_MAX;
	endproperty
	a_fail_range: assert property (p_fail_range)
		else $error("fallback level above limit");

	property p_role2_range;
		second_output_role_r <= ROLE2_MAX;
	endproperty
	a_role2_range: assert property (p_role2_range)
		else $error("output 2 role out of range");

	// a strap load shows up as a change one edge later, so skip that edge
	property p_kind2_swap;
		(!$past(strap_load) && $changed(kind2_r))
			|-> is_current(kind2_r) && is_current($past(kind2_r));
	endproperty
	a_kind2_swap: assert property (p_kind2_swap)
		else $error("output 2 kind changed outside current range");

	property p_role34_range;
		third_output_role_r <= ROLE34_MAX && fourth_output_role_r <= ROLE34_MAX;
	endproperty
	a_role34_range: assert property (p_role34_range)
		else $error("output 3 or 4 role out of range");

	property p_role4_write;
		(wr_ok && sel == SEL_ROLE4) |=> fourth_output_role_r == $past(reg_wdata[4:0]);
	endproperty
	a_role4_write: assert property (p_role4_write)
		else $error("output 4 role not stored");

	property p_event_follow;
		(first_output_role_r == ROLE1_EV1 && $stable(first_output_role_r))
			|=> out_drive[0] == $past(program_aux_event_one);
	endproperty
	a_event_follow: assert property (p_event_follow)
		else $error("output 1 does not follow program event one");

	property p_reject;
		(reg_req && reg_we && sel != SEL_NONE && !legal)
			|=> reg_ack && reg_exc == EXC_DATA && $stable(first_output_role_r)
			&& $stable(sensor_fault_drive_level_r);
	endproperty
	a_reject: assert property (p_reject)
		else $error("illegal write not rejected");

	c_reject: cover property (reg_req && reg_we && !legal && sel != SEL_NONE);
	c_swap: cover property (wr_ok && sel == SEL_KIND2);
	c_fault: cover property (sensor_fault && first_output_role_r == ROLE_CTRL);
	c_event: cover property (first_output_role_r == ROLE1_EV1 ##1 out_drive[0]);

endmodule : output_assign_regs

// ---- inc/output_assign_pkg.sv ----
// constants, types and helper functions for the output assignment registers
// assumes a single 100 MHz clock domain and register offsets as word indices
package output_assign_pkg;

	localparam int            OUT_N         = 4;
	localparam int            ROLE_W        = 5;
	localparam int            SRC_N         = 18;
	localparam logic [15:0]   ADDR_ROLE1    = 16'h0FBB;
	localparam logic [15:0]   ADDR_KIND1    = 16'h0FBC;
	localparam logic [15:0]   ADDR_FAIL     = 16'h0FBD;
	localparam logic [15:0]   ADDR_ROLE2    = 16'h0FBE;
	localparam logic [15:0]   ADDR_KIND2    = 16'h0FBF;
	localparam logic [15:0]   ADDR_ROLE3    = 16'h0FC0;
	localparam logic [15:0]   ADDR_ROLE4    = 16'h0FC1;
	localparam logic [4:0]    ROLE_NONE     = 5'h00;
	localparam logic [4:0]    ROLE_CTRL     = 5'h01;
	localparam logic [4:0]    ROLE1_MAX     = 5'h0F;
	localparam logic [4:0]    ROLE2_MAX     = 5'h11;
	localparam logic [4:0]    ROLE34_MAX    = 5'h10;
	localparam logic [4:0]    ROLE1_RETX    = 5'h0C;
	localparam logic [4:0]    ROLE1_EV1     = 5'h0D;
	localparam logic [4:0]    ROLE34_EV1    = 5'h0E;
	localparam logic [4:0]    SRC_RETX      = 5'h0E;
	localparam logic [4:0]    SRC_EV1       = 5'h0F;
	localparam logic [15:0]   FAIL_MAX      = 16'h03E8;
	localparam logic [15:0]   FAIL_RESET    = 16'h0000;
	localparam logic [2:0]    KIND_NONE     = 3'h0;
	localparam logic [2:0]    KIND_CUR_420  = 3'h3;
	localparam logic [2:0]    KIND_CUR_020  = 3'h4;
	localparam logic [7:0]    EXC_NONE      = 8'h00;
	localparam logic [7:0]    EXC_ADDR      = 8'h02;
	localparam logic [7:0]    EXC_DATA      = 8'h03;
	localparam logic [1:0]    STRAP_LOAD    = 2'h2;
	localparam logic [1:0]    STRAP_DONE    = 2'h3;

	typedef enum logic [2:0] {
		SEL_ROLE1 = 3'h0, SEL_KIND1 = 3'h1, SEL_FAIL  = 3'h2, SEL_ROLE2 = 3'h3,
		SEL_KIND2 = 3'h4, SEL_ROLE3 = 3'h5, SEL_ROLE4 = 3'h6, SEL_NONE  = 3'h7
	} reg_sel_t;

	function automatic reg_sel_t decode_addr(input logic [15:0] a);
		if (a == ADDR_ROLE1)      return SEL_ROLE1;
		else if (a == ADDR_KIND1) return SEL_KIND1;
		else if (a == ADDR_FAIL)  return SEL_FAIL;
		else if (a == ADDR_ROLE2) return SEL_ROLE2;
		else if (a == ADDR_KIND2) return SEL_KIND2;
		else if (a == ADDR_ROLE3) return SEL_ROLE3;
		else if (a == ADDR_ROLE4) return SEL_ROLE4;
		else                      return SEL_NONE;
	endfunction : decode_addr

	// the four role tables share codes 0..11 and differ above
	function automatic logic [4:0] role_to_src(input int idx, input logic [4:0] code);
		if (idx == 0)
			return (code == ROLE1_RETX) ? SRC_RETX :
				(code >= ROLE1_EV1) ? 5'(code + 5'h02) : code;
		else if (idx == 1)
			return code;
		else
			return (code >= ROLE34_EV1) ? 5'(code + 5'h01) : code;
	endfunction : role_to_src

	function automatic logic is_current(input logic [2:0] k);
		return (k == KIND_CUR_420) || (k == KIND_CUR_020);
	endfunction : is_current

endpackage : output_assign_pkg

// ---- inc/route_if.sv ----
// role codes and event sources handed to the output router
// assumes the owner drives role and src on the system clock
interface route_if
	import output_assign_pkg::*;
	#(parameter int N = OUT_N);
	logic [ROLE_W-1:0] role [N];
	logic [SRC_N-1:0]  src;
	logic [N-1:0]      drive;
	modport owner  (output role, output src, input drive);
	modport router (input role, input src, output drive);
endinterface : route_if

// ---- rtl/write_checker.sv ----
// legality check of a holding register write
// assumes sel comes from address decode and kinds hold the fitted hardware
module write_checker
	import output_assign_pkg::*;
(
	// request
	input  wire reg_sel_t    sel,
	input  wire logic [15:0] wdata,
	// present kinds
	input  wire logic [2:0]  kind1,
	input  wire logic [2:0]  kind2,
	// verdict
	output logic             legal
);
	always_comb
	begin
		legal = 1'b0;
		case (sel)
			SEL_ROLE1: legal = (wdata <= 16'(ROLE1_MAX));
			SEL_ROLE2: legal = (wdata <= 16'(ROLE2_MAX));
			SEL_ROLE3: legal = (wdata <= 16'(ROLE34_MAX));
			SEL_ROLE4: legal = (wdata <= 16'(ROLE34_MAX));
			SEL_FAIL:  legal = (wdata <= FAIL_MAX);
			// only a fitted current output may swap its range
			SEL_KIND1: legal = is_current(kind1) && (wdata[15:3] == 13'h0000)
				&& is_current(wdata[2:0]);
			SEL_KIND2: legal = is_current(kind2) && (wdata[15:3] == 13'h0000)
				&& is_current(wdata[2:0]);
			default:   legal = 1'b0;
		endcase
	end
endmodule : write_checker

// ---- rtl/output_router.sv ----
// routes one event source to each output according to its role code
// assumes role codes are already legal for their output
module output_router
	import output_assign_pkg::*;
(
	// carrier
	route_if.router rif
);
	for (genvar i = 0; i < OUT_N; i++)
	begin : g_out
		// role 0 maps to src bit 0, which the owner ties low
		assign rif.drive[i] = rif.src[role_to_src(i, rif.role[i])];
	end
endmodule : output_router

// ---- test/bus_master_model.sv ----
// remote bus master model issuing word accesses to the register port
// assumes the answer strobe comes one cycle after the taking edge
module bus_master_model
(
	// clock
	input  wire logic        clk_sys,
	// request
	output logic             reg_req,
	output logic             reg_we,
	output logic [15:0]      reg_addr,
	output logic [15:0]      reg_wdata,
	// answer
	input  wire logic        reg_ack,
	input  wire logic [15:0] reg_rdata,
	input  wire logic [7:0]  reg_exc
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		reg_req   = 1'b0;
		reg_we    = 1'b0;
		reg_addr  = 16'h0000;
		reg_wdata = 16'h0000;
	end

	task automatic access(input logic we, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] rd, output logic [7:0] ex);
		int n;
		n = 0;
		@(posedge clk_sys);
		#1;
		reg_req   = 1'b1;
		reg_we    = we;
		reg_addr  = a;
		reg_wdata = d;
		@(posedge clk_sys);
		#1;
		// pulse only; released lines flip so stale values cannot pass
		reg_req   = 1'b0;
		reg_addr  = ~a;
		reg_wdata = ~d;
		while (reg_ack !== 1'b1 && n < 4)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		rd = reg_rdata;
		ex = (reg_ack === 1'b1) ? reg_exc : 8'hFF;
	endtask : access

endmodule : bus_master_model

// ---- test/tb_top.sv ----
// self-checking bench for the output assignment registers
// assumes the master model holds the register port protocol
module tb_top
	import output_assign_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk_sys = 1'b0;
	logic        rst_n   = 1'b0;
	logic        reg_req, reg_we, reg_ack;
	logic [15:0] reg_addr, reg_wdata, reg_rdata;
	logic [7:0]  reg_exc;
	logic [2:0]  kind1_fit = 3'h3;
	logic [2:0]  kind2_fit = 3'h4;
	logic [14:1] source_evt = 14'h0000;
	logic [2:0]  aux_evt = 3'h0;
	logic        sensor_fault = 1'b0;
	logic [15:0] ctrl_level = 16'h0000;
	logic [3:0]  out_drive;
	logic [15:0] out1_level;
	logic [2:0]  first_output_kind, second_output_kind;
	int          miscompares = 0;
	int          checked = 0;
	int          cycles = 0;

	localparam logic [15:0] RANGE_ADDR [5] = '{ADDR_ROLE1, ADDR_ROLE2, ADDR_ROLE3, ADDR_ROLE4,
		ADDR_FAIL};
	localparam logic [15:0] RANGE_MAX [5] = '{16'h000F, 16'h0011, 16'h0010, 16'h0010, 16'h03E8};

	always #5 clk_sys = ~clk_sys;

	output_assign_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
		.reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
		.reg_rdata(reg_rdata), .reg_exc(reg_exc), .first_kind_fit(kind1_fit),
		.second_kind_fit(kind2_fit), .source_evt(source_evt),
		.program_aux_event_one(aux_evt[0]), .program_aux_event_two(aux_evt[1]),
		.program_aux_event_three(aux_evt[2]), .sensor_fault(sensor_fault),
		.ctrl_level(ctrl_level), .out_drive(out_drive), .out1_level(out1_level),
		.first_output_kind(first_output_kind), .second_output_kind(second_output_kind));

	bus_master_model u_master (.clk_sys(clk_sys), .reg_req(reg_req), .reg_we(reg_we),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
		.reg_rdata(reg_rdata), .reg_exc(reg_exc));

	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	// a hang counts as a mismatch; the run needs well under a thousand cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			finish_test();
		end
	end

	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(logic [15:0] a, logic [15:0] d, logic [7:0] exp_ex);
		logic [15:0] rv;
		logic [7:0]  ex;
		u_master.access(1'b1, a, d, rv, ex);
		check($sformatf("write answer %h", a), {8'h00, ex}, {8'h00, exp_ex});
	endtask : wr

	task automatic rd(logic [15:0] a, logic [15:0] exp);
		logic [15:0] rv;
		logic [7:0]  ex;
		u_master.access(1'b0, a, 16'h0000, rv, ex);
		check($sformatf("read answer %h", a), {8'h00, ex}, {8'h00, EXC_NONE});
		check($sformatf("read data %h", a), rv, exp);
	endtask : rd

	task automatic do_reset(logic [2:0] k1, logic [2:0] k2);
		@(posedge clk_sys);
		#1;
		rst_n     = 1'b0;
		kind1_fit = k1;
		kind2_fit = k2;
		repeat (8) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		// straps reach the kind registers only a few edges after release
		repeat (4) @(posedge clk_sys);
	endtask : do_reset

	task automatic drive_evt(logic [2:0] ev, logic [14:1] src, logic [3:0] exp);
		@(posedge clk_sys);
		#1;
		aux_evt    = ev;
		source_evt = src;
		repeat (2) @(posedge clk_sys);
		#1;
		check("out drive", {12'h000, out_drive}, {12'h000, exp});
	endtask : drive_evt

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		do_reset(KIND_CUR_420, KIND_CUR_020);
		for (int i = 0; i < 5; i++)
			rd(RANGE_ADDR[i], 16'h0000);
		rd(ADDR_KIND1, 16'h0003);
		rd(ADDR_KIND2, 16'h0004);
		wr(16'h0FC2, 16'h0001, EXC_ADDR);
		for (int i = 0; i < 5; i++)
		begin
			wr(RANGE_ADDR[i], RANGE_MAX[i], EXC_NONE);
			wr(RANGE_ADDR[i], RANGE_MAX[i] + 16'h0001, EXC_DATA);
			rd(RANGE_ADDR[i], RANGE_MAX[i]);
		end
		wr(ADDR_KIND1, 16'h0004, EXC_NONE);
		wr(ADDR_KIND1, 16'h0006, EXC_DATA);
		rd(ADDR_KIND1, 16'h0004);
		check("first kind", {13'h0000, first_output_kind}, 16'h0004);
		wr(ADDR_KIND2, 16'h0003, EXC_NONE);
		wr(ADDR_KIND2, 16'h0005, EXC_DATA);
		rd(ADDR_KIND2, 16'h0003);
		check("second kind", {13'h0000, second_output_kind}, 16'h0003);
		// event roles on the first three outputs, source 10 on the fourth
		wr(ADDR_ROLE1, 16'h000D, EXC_NONE);
		wr(ADDR_ROLE2, 16'h0011, EXC_NONE);
		wr(ADDR_ROLE3, 16'h0010, EXC_NONE);
		wr(ADDR_ROLE4, 16'h000A, EXC_NONE);
		drive_evt(3'h5, 14'h0000, 4'h7);
		drive_evt(3'h2, 14'h0000, 4'h0);
		drive_evt(3'h0, 14'h0200, 4'h8);
		wr(ADDR_ROLE1, 16'h000C, EXC_NONE);
		drive_evt(3'h0, 14'h2000, 4'h1);
		// fallback level while the sensor is damaged
		wr(ADDR_ROLE1, 16'h0001, EXC_NONE);
		wr(ADDR_FAIL, 16'h01F4, EXC_NONE);
		ctrl_level   = 16'h007B;
		sensor_fault = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		check("fallback level", out1_level, 16'h01F4);
		sensor_fault = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		check("control level", out1_level, 16'h007B);
		// non-current hardware keeps its kind fixed
		do_reset(3'h1, 3'h0);
		wr(ADDR_KIND1, 16'h0003, EXC_DATA);
		rd(ADDR_KIND1, 16'h0001);
		wr(ADDR_KIND2, 16'h0004, EXC_DATA);
		rd(ADDR_KIND2, 16'h0000);
		finish_test();
	end

endmodule : tb_top
